// [core/mcu_instruction_execute_unit.v]
// Instruction fetch, decode and execute for an eight-bit single-accumulator core.
// Assumes program and data memories answer reads combinationally in the same cycle.
`timescale 1ns/1ps
`include "exec_unit_defs.vh"

module mcu_instruction_execute_unit (
  input  wire                clk_i,
  input  wire                rst_b_i,
  output wire [`PC_W-1:0]    prog_addr_o,
  input  wire [15:0]         prog_data_i,
  output wire [6:0]          dmem_addr_o,
  input  wire [7:0]          dmem_rdata_i,
  output reg  [7:0]          dmem_wdata_o,
  output reg                 dmem_we_o,
  input  wire [7:0]          table_pointer_i,
  input  wire [2:0]          table_page_i,
  input  wire                wake_i,
  input  wire                watchdog_timeout_i,
  input  wire                interrupt_entry_i,
  output reg  [7:0]          working_register_o,
  output reg  [7:0]          table_high_byte_reg_o,
  output reg                 carry_flag_o,
  output reg                 zero_flag_o,
  output reg                 auxiliary_carry_flag_o,
  output reg                 overflow_flag_o,
  output reg                 watchdog_timeout_flag_o,
  output reg                 power_down_flag_o,
  output reg                 global_interrupt_enable_o,
  output reg                 watchdog_counter_clear_o,
  output wire                clock_stop_o
);

  localparam ST_RUN  = 1'b0;
  localparam ST_HALT = 1'b1;

  function [7:0] bit_mask;
    input [2:0] idx;
    begin
      bit_mask = 8'h01 << idx;
    end
  endfunction

  // ======================================================================
  // State
  reg              state;
  reg [`PC_W-1:0]  pc;
  reg [15:0]       ir;
  reg              ir_valid;
  reg [`SP_W-1:0]  sp;
  reg [`PC_W-1:0]  stack [0:`STACK_DEPTH-1];
  reg              last_pre1;
  reg              last_pre2;
  reg              wake_meta;
  reg              wake_sync;

  reg              next_state;
  reg [`PC_W-1:0]  next_pc;
  reg              next_ir_valid;
  reg [7:0]        next_acc;
  reg              acc_we;
  reg              flag4_we;
  reg              zero_we;
  reg              skip;
  reg              branch;
  reg [`PC_W-1:0]  target;
  reg              push;
  reg              pop;
  reg              tbl_read;
  reg [`PC_W-1:0]  tbl_addr;
  reg              wdt_clr;
  reg              halt_go;
  reg              gie_set;
  reg              is_pre1;
  reg              is_pre2;
  reg              alu_op;
  reg  [7:0]       alu_a;
  reg  [7:0]       alu_b;
  reg              alu_cin;

  wire [5:0]       op    = ir[`OP_HI:`OP_LO];
  wire [7:0]       imm   = ir[`IMM_HI:`IMM_LO];
  wire [7:0]       mask  = bit_mask(ir[`BIT_HI:`BIT_LO]);
  wire [7:0]       mem   = dmem_rdata_i;
  wire             exec  = ir_valid && (state == ST_RUN);
  wire [7:0]       alu_res;
  wire             alu_c;
  wire             alu_ac;
  wire             alu_ov;
  wire             alu_z;

  assign dmem_addr_o  = ir[`ADDR_HI:`ADDR_LO];
  assign prog_addr_o  = tbl_read ? tbl_addr : pc;
  assign clock_stop_o = (state == ST_HALT);

  exec_alu8 u_alu (
    .op_i        (alu_op),
    .a_i         (alu_a),
    .b_i         (alu_b),
    .cin_i       (alu_cin),
    .result_o    (alu_res),
    .carry_o     (alu_c),
    .aux_carry_o (alu_ac),
    .overflow_o  (alu_ov),
    .zero_o      (alu_z)
  );

  // ======================================================================
  // Decode and execute
  always @* begin
    next_acc     = working_register_o;
    acc_we       = 1'b0;
    dmem_we_o    = 1'b0;
    dmem_wdata_o = 8'h00;
    flag4_we     = 1'b0;
    zero_we      = 1'b0;
    skip         = 1'b0;
    branch       = 1'b0;
    target       = pc;
    push         = 1'b0;
    pop          = 1'b0;
    tbl_read     = 1'b0;
    tbl_addr     = {table_page_i, table_pointer_i};
    wdt_clr      = 1'b0;
    halt_go      = 1'b0;
    gie_set      = 1'b0;
    is_pre1      = 1'b0;
    is_pre2      = 1'b0;
    alu_op       = `ALU_ADD;
    alu_a        = working_register_o;
    alu_b        = mem;
    alu_cin      = 1'b0;
    if (exec) begin
      if (ir[`BRANCH_HI:`BRANCH_LO] == `OP5_JUMP) begin
        branch = 1'b1;
        target = ir[`TGT_HI:`TGT_LO];
      end else if (ir[`BRANCH_HI:`BRANCH_LO] == `OP5_CALL) begin
        branch = 1'b1;
        push   = 1'b1;
        target = ir[`TGT_HI:`TGT_LO];
      end else begin
        case (op)
          `OP_MOV_A_M: begin acc_we = 1'b1; next_acc = mem; end
          `OP_MOV_M_A: begin dmem_we_o = 1'b1; dmem_wdata_o = working_register_o; end
          `OP_MOV_A_I: begin acc_we = 1'b1; next_acc = imm; end
          `OP_CLR_BIT: begin dmem_we_o = 1'b1; dmem_wdata_o = mem & ~mask; end
          `OP_SET_BIT: begin dmem_we_o = 1'b1; dmem_wdata_o = mem | mask; end
          `OP_SKIP_ZERO: skip = (mem == 8'h00);
          `OP_SKIP_ZERO_A: begin
            skip     = (mem == 8'h00);
            acc_we   = 1'b1;
            next_acc = mem;
          end
          `OP_SKIP_BIT_Z:  skip = ((mem & mask) == 8'h00);
          `OP_SKIP_BIT_NZ: skip = ((mem & mask) != 8'h00);
          `OP_INC_SKIP, `OP_DEC_SKIP, `OP_INC_SKIP_A, `OP_DEC_SKIP_A: begin
            alu_a = mem;
            alu_b = (op == `OP_INC_SKIP || op == `OP_INC_SKIP_A) ? 8'h01 : 8'hff;
            skip  = alu_z;
            if (op == `OP_INC_SKIP || op == `OP_DEC_SKIP) begin
              dmem_we_o    = 1'b1;
              dmem_wdata_o = alu_res;
            end else begin
              acc_we   = 1'b1;
              next_acc = alu_res;
            end
          end
          `OP_RET: begin branch = 1'b1; pop = 1'b1; end
          `OP_RET_A_I: begin
            branch   = 1'b1;
            pop      = 1'b1;
            acc_we   = 1'b1;
            next_acc = imm;
          end
          `OP_INT_RET: begin branch = 1'b1; pop = 1'b1; gie_set = 1'b1; end
          `OP_TBL_SPEC, `OP_TBL_CUR, `OP_TBL_LAST: begin
            tbl_read = 1'b1;
            if (op == `OP_TBL_CUR) begin
              tbl_addr = {pc[`PC_W-1:8], table_pointer_i};
            end else if (op == `OP_TBL_LAST) begin
              tbl_addr = {`LAST_PAGE, table_pointer_i};
            end
            dmem_we_o    = 1'b1;
            dmem_wdata_o = prog_data_i[7:0];
          end
          `OP_CLR_M: begin dmem_we_o = 1'b1; dmem_wdata_o = 8'h00; end
          `OP_SET_M: begin dmem_we_o = 1'b1; dmem_wdata_o = 8'hff; end
          `OP_WDT_CLR:  wdt_clr = 1'b1;
          `OP_WDT_PRE1: begin is_pre1 = 1'b1; wdt_clr = last_pre2; end
          `OP_WDT_PRE2: begin is_pre2 = 1'b1; wdt_clr = last_pre1; end
          `OP_SWAP_M: begin dmem_we_o = 1'b1; dmem_wdata_o = {mem[3:0], mem[7:4]}; end
          `OP_SWAP_A: begin acc_we = 1'b1; next_acc = {mem[3:0], mem[7:4]}; end
          `OP_HALT: halt_go = 1'b1;
          `OP_ADC_A, `OP_ADC_M, `OP_ADD_A, `OP_ADD_A_I, `OP_ADD_M: begin
            alu_cin  = (op == `OP_ADC_A || op == `OP_ADC_M) ? carry_flag_o : 1'b0;
            alu_b    = (op == `OP_ADD_A_I) ? imm : mem;
            flag4_we = 1'b1;
            if (op == `OP_ADC_M || op == `OP_ADD_M) begin
              dmem_we_o    = 1'b1;
              dmem_wdata_o = alu_res;
            end else begin
              acc_we   = 1'b1;
              next_acc = alu_res;
            end
          end
          `OP_AND_A, `OP_AND_A_I: begin
            alu_op   = `ALU_AND;
            alu_b    = (op == `OP_AND_A_I) ? imm : mem;
            zero_we  = 1'b1;
            acc_we   = 1'b1;
            next_acc = alu_res;
          end
          `OP_AND_M: begin
            alu_op       = `ALU_AND;
            zero_we      = 1'b1;
            dmem_we_o    = 1'b1;
            dmem_wdata_o = alu_res;
          end
          default: begin
          end
        endcase
        if (pop) begin
          target = stack[sp - 3'd1];
        end
        // A store into the counter low byte redirects fetch and costs a dead cycle.
        if (dmem_we_o && dmem_addr_o == `PCL_ADDR) begin
          branch = 1'b1;
          target = {pc[`PC_W-1:8], dmem_wdata_o};
        end
      end
    end
  end

  // ======================================================================
  // Sequencing: a flushed slot is the second cycle of branches, skips and table reads.
  always @* begin
    next_state    = state;
    next_pc       = pc;
    next_ir_valid = 1'b1;
    case (state)
      ST_RUN: begin
        if (halt_go) begin
          next_state = ST_HALT;
        end else if (branch) begin
          next_pc       = target;
          next_ir_valid = 1'b0;
        end else if (tbl_read) begin
          next_ir_valid = 1'b0;
        end else if (skip) begin
          next_pc       = pc + 11'd1;
          next_ir_valid = 1'b0;
        end else begin
          next_pc = pc + 11'd1;
        end
      end
      ST_HALT: begin
        next_ir_valid = 1'b0;
        if (wake_sync) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  // ======================================================================
  // Registers
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state                     <= ST_RUN;
      pc                        <= `PC_RESET;
      ir                        <= 16'h0000;
      ir_valid                  <= 1'b0;
      sp                        <= 3'd0;
      last_pre1                 <= 1'b0;
      last_pre2                 <= 1'b0;
      wake_meta                 <= 1'b0;
      wake_sync                 <= 1'b0;
      working_register_o        <= `ACC_RESET;
      table_high_byte_reg_o     <= `TABLE_HIGH_BYTE_REG_RESET;
      carry_flag_o              <= 1'b0;
      zero_flag_o               <= 1'b0;
      auxiliary_carry_flag_o    <= 1'b0;
      overflow_flag_o           <= 1'b0;
      watchdog_timeout_flag_o   <= 1'b0;
      power_down_flag_o         <= 1'b0;
      global_interrupt_enable_o <= 1'b0;
      watchdog_counter_clear_o  <= 1'b0;
    end else begin
      wake_meta <= wake_i;
      wake_sync <= wake_meta;
      state     <= next_state;
      pc        <= next_pc;
      ir_valid  <= next_ir_valid;
      if (state == ST_RUN && !halt_go) begin
        ir <= prog_data_i;
      end
      if (exec) begin
        last_pre1 <= is_pre1;
        last_pre2 <= is_pre2;
      end
      if (push) begin
        stack[sp] <= pc;
        sp        <= sp + 3'd1;
      end else if (pop) begin
        sp <= sp - 3'd1;
      end
      if (acc_we) begin
        working_register_o <= next_acc;
      end
      if (tbl_read) begin
        table_high_byte_reg_o <= prog_data_i[15:8];
      end
      if (flag4_we) begin
        carry_flag_o           <= alu_c;
        auxiliary_carry_flag_o <= alu_ac;
        overflow_flag_o        <= alu_ov;
      end
      if (flag4_we || zero_we) begin
        zero_flag_o <= alu_z;
      end
      // A timeout from the watchdog counter wins over a clear in the same cycle.
      if (watchdog_timeout_i) begin
        watchdog_timeout_flag_o <= 1'b1;
      end else if (wdt_clr || halt_go) begin
        watchdog_timeout_flag_o <= 1'b0;
      end
      if (halt_go) begin
        power_down_flag_o <= 1'b1;
      end else if (wdt_clr) begin
        power_down_flag_o <= 1'b0;
      end
      watchdog_counter_clear_o <= wdt_clr || halt_go;
      if (gie_set) begin
        global_interrupt_enable_o <= 1'b1;
      end else if (interrupt_entry_i) begin
        global_interrupt_enable_o <= 1'b0;
      end
    end
  end

endmodule

// [core/exec_unit_defs.vh]
// Constants of the instruction execute unit: opcodes, field positions, sizes and reset values.
// Assumes inclusion by bare name from the design files of the execute unit.
`ifndef EXEC_UNIT_DEFS_VH
`define EXEC_UNIT_DEFS_VH

// ======================================================================
// Instruction word fields
`define OP_HI          15
`define OP_LO          10
`define BIT_HI         9
`define BIT_LO         7
`define ADDR_HI        6
`define ADDR_LO        0
`define IMM_HI         7
`define IMM_LO         0
`define TGT_HI         10
`define TGT_LO         0
`define BRANCH_HI      15
`define BRANCH_LO      11

// ======================================================================
// Opcodes (six-bit field; jump and call use only the top five bits)
`define OP_NOP         6'h00
`define OP_MOV_A_M     6'h01
`define OP_MOV_M_A     6'h02
`define OP_MOV_A_I     6'h03
`define OP_CLR_BIT     6'h04
`define OP_SET_BIT     6'h05
`define OP_SKIP_ZERO   6'h06
`define OP_SKIP_ZERO_A 6'h07
`define OP_SKIP_BIT_Z  6'h08
`define OP_SKIP_BIT_NZ 6'h09
`define OP_INC_SKIP    6'h0a
`define OP_DEC_SKIP    6'h0b
`define OP_INC_SKIP_A  6'h0c
`define OP_DEC_SKIP_A  6'h0d
`define OP_RET         6'h0e
`define OP_RET_A_I     6'h0f
`define OP_INT_RET     6'h10
`define OP_TBL_SPEC    6'h11
`define OP_TBL_CUR     6'h12
`define OP_TBL_LAST    6'h13
`define OP_CLR_M       6'h14
`define OP_SET_M       6'h15
`define OP_WDT_CLR     6'h16
`define OP_WDT_PRE1    6'h17
`define OP_WDT_PRE2    6'h18
`define OP_SWAP_M      6'h19
`define OP_SWAP_A      6'h1a
`define OP_HALT        6'h1b
`define OP_ADC_A       6'h1c
`define OP_ADC_M       6'h1d
`define OP_ADD_A       6'h1e
`define OP_ADD_A_I     6'h1f
`define OP_ADD_M       6'h20
`define OP_AND_A       6'h21
`define OP_AND_A_I     6'h22
`define OP_AND_M       6'h23
`define OP5_JUMP       5'h1e
`define OP5_CALL       5'h1f

// ======================================================================
// ALU operation codes
`define ALU_ADD        1'b0
`define ALU_AND        1'b1

// ======================================================================
// Sizes, addresses and reset values
`define PC_W           11
`define STACK_DEPTH    6
`define SP_W           3
`define PCL_ADDR       7'h06
`define LAST_PAGE      3'h7
`define PC_RESET       11'h000
`define ACC_RESET      8'h00
`define TABLE_HIGH_BYTE_REG_RESET     8'h00

`endif

// [core/exec_alu8.v]
// Eight-bit adder and AND unit with flag outputs for the execute unit.
// Assumes purely combinational use by the execute unit on the same clock.
`timescale 1ns/1ps
`include "exec_unit_defs.vh"

module exec_alu8 (
  input  wire       op_i,
  input  wire [7:0] a_i,
  input  wire [7:0] b_i,
  input  wire       cin_i,
  output reg  [7:0] result_o,
  output reg        carry_o,
  output reg        aux_carry_o,
  output reg        overflow_o,
  output wire       zero_o
);

  reg [8:0] sum;
  reg [4:0] half;

  // ======================================================================
  // Arithmetic
  always @* begin
    sum  = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
    half = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
    if (op_i == `ALU_AND) begin
      result_o = a_i & b_i;
    end else begin
      result_o = sum[7:0];
    end
    carry_o     = sum[8];
    aux_carry_o = half[4];
    overflow_o  = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
  end

  assign zero_o = (result_o == 8'h00);

endmodule

// [testbench/mem_model.sv]
// Program and data memories that stand beside the execute unit.
// Assumes one clock; reads answer at once, data writes land at the rising edge.
`timescale 1ns/1ps
module mem_model (
  input  wire        clk_i,
  input  wire [10:0] prog_addr_i,
  output wire [15:0] prog_data_o,
  input  wire [6:0]  dmem_addr_i,
  output wire [7:0]  dmem_rdata_o,
  input  wire [7:0]  dmem_wdata_i,
  input  wire        dmem_we_i
);
  logic [15:0] prog [0:2047];
  logic [7:0]  data [0:127];
  // ======================================================================
  // Read and write ports
  // Table words come through the fetch port, so one array serves both uses.
  assign prog_data_o  = prog[prog_addr_i];
  assign dmem_rdata_o = data[dmem_addr_i];
  always @(posedge clk_i) begin
    if (dmem_we_i) begin
      data[dmem_addr_i] <= dmem_wdata_i;
    end
  end
endmodule

// [testbench/exec_unit_chk.sv]
// Port-level assertions on the execute unit.
// Assumes one clock domain and a bind onto the unit's top module.
`timescale 1ns/1ps
`include "exec_unit_defs.vh"
module exec_unit_chk (
  input wire       clk_i,
  input wire       rst_b_i,
  input wire [10:0] prog_addr_o,
  input wire [6:0] dmem_addr_o,
  input wire       dmem_we_o,
  input wire [7:0] table_high_byte_reg_o,
  input wire       watchdog_timeout_i,
  input wire       interrupt_entry_i,
  input wire       watchdog_timeout_flag_o,
  input wire       power_down_flag_o,
  input wire       global_interrupt_enable_o,
  input wire       watchdog_counter_clear_o,
  input wire       clock_stop_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ======================================================================
  // Power-down, watchdog and interrupt entry
  property p_halt_enter;
    $rose(clock_stop_o) |-> power_down_flag_o && !watchdog_timeout_flag_o;
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("power-down flags wrong");
  property p_halt_hold;
    clock_stop_o && $past(clock_stop_o) |-> $stable(prog_addr_o);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("fetch moved in power-down");
  property p_halt_nowrite;
    clock_stop_o |-> !dmem_we_o;
  endproperty
  a_halt_nowrite: assert property (p_halt_nowrite) else $error("write in power-down");
  property p_clr_pulse;
    watchdog_counter_clear_o |=> !watchdog_counter_clear_o;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse too long");
  property p_clr_flag;
    watchdog_counter_clear_o |-> !watchdog_timeout_flag_o;
  endproperty
  a_clr_flag: assert property (p_clr_flag) else $error("timeout flag kept");
  property p_to_set;
    watchdog_timeout_i |=> watchdog_timeout_flag_o;
  endproperty
  a_to_set: assert property (p_to_set) else $error("timeout flag not set");
  property p_int_entry;
    interrupt_entry_i |=> !global_interrupt_enable_o;
  endproperty
  a_int_entry: assert property (p_int_entry) else $error("enable kept on entry");
  // ======================================================================
  // Dead slots
  property p_pcl_dead;
    dmem_we_o && dmem_addr_o == `PCL_ADDR |=> !dmem_we_o;
  endproperty
  a_pcl_dead: assert property (p_pcl_dead) else $error("slot after counter write ran");
  property p_tbl_dead;
    $changed(table_high_byte_reg_o) |-> $past(dmem_we_o) && !dmem_we_o;
  endproperty
  a_tbl_dead: assert property (p_tbl_dead) else $error("table read not paired");
  c_halt: cover property ($rose(clock_stop_o));
  c_tbl: cover property ($changed(table_high_byte_reg_o));
  c_pcl: cover property (dmem_we_o && dmem_addr_o == `PCL_ADDR);
endmodule
bind mcu_instruction_execute_unit exec_unit_chk exec_unit_chk_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .prog_addr_o(prog_addr_o), .dmem_addr_o(dmem_addr_o), .dmem_we_o(dmem_we_o),
  .table_high_byte_reg_o(table_high_byte_reg_o), .watchdog_timeout_i(watchdog_timeout_i),
  .interrupt_entry_i(interrupt_entry_i), .watchdog_timeout_flag_o(watchdog_timeout_flag_o),
  .power_down_flag_o(power_down_flag_o), .global_interrupt_enable_o(global_interrupt_enable_o),
  .watchdog_counter_clear_o(watchdog_counter_clear_o), .clock_stop_o(clock_stop_o));

// [testbench/tb_top.sv]
// Self-checking bench of the execute unit with its memories.
// Assumes the memory model answers at once; cycle marks come from marker writes.
`timescale 1ns/1ps
`include "exec_unit_defs.vh"
module tb_top;
  typedef struct {logic c; logic [5:0] op; logic [9:0] lo; logic [7:0] m, a, ea, em; logic [3:0] fl; logic sk;} row_t;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        wake_i = 1'b0;
  logic        watchdog_timeout_i = 1'b0;
  logic        interrupt_entry_i = 1'b0;
  logic [7:0]  table_pointer_i = 8'h80;
  logic [2:0]  table_page_i = 3'h5;
  wire  [10:0] prog_addr_o;
  wire  [15:0] prog_data_i;
  wire  [6:0]  dmem_addr_o;
  wire  [7:0]  dmem_rdata_i, dmem_wdata_o, working_register_o, table_high_byte_reg_o;
  wire         dmem_we_o, carry_flag_o, zero_flag_o, auxiliary_carry_flag_o, overflow_flag_o;
  wire         watchdog_timeout_flag_o, power_down_flag_o, global_interrupt_enable_o;
  wire         watchdog_counter_clear_o, clock_stop_o;
  int          fails = 0, compares = 0, cyc = 0, pulses = 0;
  int          we_cyc [0:127];
  row_t        rows [$];
  logic [5:0]  tail [10] = '{`OP_WDT_PRE1, `OP_NOP, `OP_WDT_PRE2, `OP_WDT_PRE2, `OP_WDT_PRE1, `OP_NOP,
                             `OP_WDT_CLR, `OP_NOP, `OP_HALT, `OP_SET_M};
  mcu_instruction_execute_unit mcu_instruction_execute_unit_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i), .dmem_addr_o(dmem_addr_o),
    .dmem_rdata_i(dmem_rdata_i), .dmem_wdata_o(dmem_wdata_o), .dmem_we_o(dmem_we_o),
    .table_pointer_i(table_pointer_i), .table_page_i(table_page_i), .wake_i(wake_i),
    .watchdog_timeout_i(watchdog_timeout_i), .interrupt_entry_i(interrupt_entry_i),
    .working_register_o(working_register_o), .table_high_byte_reg_o(table_high_byte_reg_o),
    .carry_flag_o(carry_flag_o), .zero_flag_o(zero_flag_o), .auxiliary_carry_flag_o(auxiliary_carry_flag_o),
    .overflow_flag_o(overflow_flag_o), .watchdog_timeout_flag_o(watchdog_timeout_flag_o),
    .power_down_flag_o(power_down_flag_o), .global_interrupt_enable_o(global_interrupt_enable_o),
    .watchdog_counter_clear_o(watchdog_counter_clear_o), .clock_stop_o(clock_stop_o));
  mem_model mem_model_inst (.clk_i(clk_i), .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i),
    .dmem_addr_i(dmem_addr_o), .dmem_rdata_o(dmem_rdata_i), .dmem_wdata_i(dmem_wdata_o), .dmem_we_i(dmem_we_o));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // Marker writes record their cycle, so instruction lengths show as gaps between markers.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (dmem_we_o === 1'b1) we_cyc[dmem_addr_o] <= cyc;
    if (watchdog_counter_clear_o === 1'b1) pulses <= pulses + 1;
  end
  // ======================================================================
  // Tasks
  function automatic logic [15:0] w(input logic [5:0] op, input logic [9:0] lo);
    return {op, lo};
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chki(input int got, input int exp);
    compares++;
    if (got != exp) begin
      fails++;
      $display("[ERR] %0t cycle gap %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic add(input logic c, input logic [5:0] op, input logic [9:0] lo, input logic [7:0] m, a, ea, em,
                     input logic [3:0] fl, input logic sk);
    rows.push_back('{c, op, lo, m, a, ea, em, fl, sk});
  endtask
  task automatic pw(input int a, input logic [15:0] v);
    mem_model_inst.prog[a] = v;
  endtask
  task automatic hold_reset();
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    #1;
    for (int i = 0; i < 2048; i++) mem_model_inst.prog[i] = 16'h0000;
    for (int i = 0; i < 128; i++) mem_model_inst.data[i] = 8'h00;
  endtask
  task automatic release_reset();
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
  endtask
  task automatic finish_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #1ms;
    fails++;
    finish_test();
  end
  // ======================================================================
  // Tests
  initial begin
    add(0, `OP_MOV_A_M, 10'h010, 8'h3c, 8'h00, 8'h3c, 8'h3c, 4'h0, 0);
    add(1, `OP_MOV_M_A, 10'h010, 8'h00, 8'ha5, 8'ha5, 8'ha5, 4'h7, 0);
    add(1, `OP_MOV_A_I, 10'h05a, 8'h00, 8'h00, 8'h5a, 8'h00, 4'h7, 0);
    add(1, `OP_CLR_BIT, 10'h190, 8'hff, 8'h00, 8'h00, 8'hf7, 4'h7, 0);
    add(0, `OP_SET_BIT, 10'h010, 8'h00, 8'h00, 8'h00, 8'h01, 4'h0, 0);
    add(1, `OP_SKIP_ZERO, 10'h010, 8'h00, 8'h11, 8'h11, 8'h00, 4'h7, 1);
    add(0, `OP_SKIP_ZERO_A, 10'h010, 8'h00, 8'h11, 8'h00, 8'h00, 4'h0, 1);
    add(0, `OP_SKIP_ZERO, 10'h010, 8'h01, 8'h11, 8'h11, 8'h01, 4'h0, 0);
    add(0, `OP_SKIP_BIT_Z, 10'h110, 8'hfb, 8'h11, 8'h11, 8'hfb, 4'h0, 1);
    add(0, `OP_SKIP_BIT_NZ, 10'h110, 8'h04, 8'h11, 8'h11, 8'h04, 4'h0, 1);
    add(0, `OP_SKIP_BIT_NZ, 10'h110, 8'hfb, 8'h11, 8'h11, 8'hfb, 4'h0, 0);
    add(1, `OP_INC_SKIP, 10'h010, 8'hff, 8'h11, 8'h11, 8'h00, 4'h7, 1);
    add(0, `OP_DEC_SKIP, 10'h010, 8'h02, 8'h11, 8'h11, 8'h01, 4'h0, 0);
    add(0, `OP_INC_SKIP_A, 10'h010, 8'h05, 8'h11, 8'h06, 8'h05, 4'h0, 0);
    add(0, `OP_DEC_SKIP_A, 10'h010, 8'h01, 8'h11, 8'h00, 8'h01, 4'h0, 1);
    add(1, `OP_CLR_M, 10'h010, 8'h5a, 8'h11, 8'h11, 8'h00, 4'h7, 0);
    add(1, `OP_SET_M, 10'h010, 8'h5a, 8'h11, 8'h11, 8'hff, 4'h7, 0);
    add(1, `OP_SWAP_M, 10'h010, 8'h3c, 8'h11, 8'h11, 8'hc3, 4'h7, 0);
    add(0, `OP_SWAP_A, 10'h010, 8'h12, 8'h11, 8'h21, 8'h12, 4'h0, 0);
    add(1, `OP_ADC_A, 10'h010, 8'h70, 8'h0f, 8'h80, 8'h70, 4'ha, 0);
    add(0, `OP_ADC_M, 10'h010, 8'h80, 8'h80, 8'h80, 8'h00, 4'hd, 0);
    add(1, `OP_ADD_A, 10'h010, 8'h01, 8'h01, 8'h02, 8'h01, 4'h0, 0);
    add(0, `OP_ADD_A_I, 10'h0ff, 8'h00, 8'h01, 8'h00, 8'h00, 4'h7, 0);
    add(0, `OP_ADD_M, 10'h010, 8'h01, 8'h7f, 8'h7f, 8'h80, 4'ha, 0);
    add(1, `OP_AND_A, 10'h010, 8'h3c, 8'hf0, 8'h30, 8'h3c, 4'h3, 0);
    add(0, `OP_AND_A_I, 10'h0f0, 8'h00, 8'h0f, 8'h00, 8'h00, 4'h4, 0);
    add(0, `OP_AND_M, 10'h010, 8'h3c, 8'h0f, 8'h0f, 8'h0c, 4'h0, 0);
    foreach (rows[i]) begin
      hold_reset();
      mem_model_inst.data[16] = rows[i].m;
      pw(0, w(`OP_MOV_A_I, 10'h0ff));
      pw(1, rows[i].c ? w(`OP_ADD_A_I, 10'h001) : 16'h0000);
      pw(2, w(`OP_MOV_A_I, {2'b00, rows[i].a}));
      pw(3, w(`OP_SET_M, 10'h013));
      pw(4, w(rows[i].op, rows[i].lo));
      pw(5, w(`OP_SET_M, 10'h011));
      pw(6, w(`OP_SET_M, 10'h012));
      release_reset();
      repeat (14) @(posedge clk_i);
      #1;
      chk8(working_register_o, rows[i].ea);
      chk8(mem_model_inst.data[16], rows[i].em);
      chk8({overflow_flag_o, zero_flag_o, auxiliary_carry_flag_o, carry_flag_o}, rows[i].fl);
      chk8(mem_model_inst.data[17], rows[i].sk ? 8'h00 : 8'hff);
      chki(we_cyc[18] - we_cyc[19], 3);
    end
    hold_reset();
    pw(0, w(`OP_SET_M, 10'h020));
    pw(1, {`OP5_JUMP, 11'h008});
    pw(2, w(`OP_SET_M, 10'h03f));
    pw(8, w(`OP_SET_M, 10'h021));
    pw(9, {`OP5_CALL, 11'h030});
    pw(10, w(`OP_MOV_M_A, 10'h022));
    pw(11, {`OP5_CALL, 11'h038});
    pw(12, w(`OP_SET_M, 10'h023));
    pw(13, w(`OP_MOV_A_I, 10'h040));
    pw(14, w(`OP_MOV_M_A, 10'h006));
    pw(15, w(`OP_SET_M, 10'h03f));
    pw(48, w(`OP_RET_A_I, 10'h077));
    pw(56, w(`OP_INT_RET, 10'h000));
    pw(64, w(`OP_SET_M, 10'h024));
    pw(65, w(`OP_TBL_SPEC, 10'h025));
    pw(66, w(`OP_TBL_CUR, 10'h026));
    pw(67, w(`OP_TBL_LAST, 10'h027));
    pw(68, w(`OP_SET_M, 10'h028));
    for (int i = 0; i < 10; i++) pw(69 + i, w(tail[i], 10'h029));
    pw(11'h580, 16'hab5a);
    pw(11'h080, 16'hcd3c);
    pw(11'h780, 16'hef96);
    release_reset();
    @(posedge clk_i);
    watchdog_timeout_i <= 1'b1;
    interrupt_entry_i <= 1'b1;
    @(posedge clk_i);
    watchdog_timeout_i <= 1'b0;
    interrupt_entry_i <= 1'b0;
    repeat (50) @(posedge clk_i);
    #1;
    chki(we_cyc[33] - we_cyc[32], 3);
    chki(we_cyc[34] - we_cyc[33], 5);
    chki(we_cyc[35] - we_cyc[34], 5);
    chki(we_cyc[36] - we_cyc[35], 4);
    chki(we_cyc[38] - we_cyc[37], 2);
    chki(we_cyc[39] - we_cyc[38], 2);
    chki(we_cyc[40] - we_cyc[39], 2);
    chk8(mem_model_inst.data[34], 8'h77);
    chk8(mem_model_inst.data[63], 8'h00);
    chk8(mem_model_inst.data[37], 8'h5a);
    chk8(mem_model_inst.data[38], 8'h3c);
    chk8(mem_model_inst.data[39], 8'h96);
    chk8(table_high_byte_reg_o, 8'hef);
    chk8({7'h0, global_interrupt_enable_o}, 8'h01);
    chki(pulses, 3);
    chk8({5'h0, clock_stop_o, power_down_flag_o, watchdog_timeout_flag_o}, 8'h06);
    chk8(mem_model_inst.data[41], 8'h00);
    @(posedge clk_i);
    wake_i <= 1'b1;
    for (int k = 0; k < 20 && clock_stop_o !== 1'b0; k++) @(posedge clk_i);
    wake_i <= 1'b0;
    interrupt_entry_i <= 1'b1;
    @(posedge clk_i);
    interrupt_entry_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk8(mem_model_inst.data[41], 8'hff);
    chk8({7'h0, global_interrupt_enable_o}, 8'h00);
    hold_reset();
    chk8(working_register_o, 8'h00);
    chk8({table_high_byte_reg_o[3:0], power_down_flag_o, watchdog_timeout_flag_o, 2'b00}, 8'h00);
    finish_test();
  end
endmodule
